// ---- hpc_defines.svh ----
// register offsets, field positions, reset values and timing figures of the playback control bank
`ifndef HPC_DEFINES_SVH
`define HPC_DEFINES_SVH

// register offsets
`define HPC_OFS_LIMITS 8'h20
`define HPC_OFS_TOP 8'h22
`define HPC_OFS_LEVEL 8'h23
`define HPC_OFS_SEQ 8'h24
`define HPC_OFS_COEF1 8'h25
`define HPC_OFS_LOOPCFG 8'h30
`define HPC_OFS_STATUS 8'h31

// field positions
`define HPC_BRAKE_MSB 6
`define HPC_BRAKE_LSB 4
`define HPC_TRACK_MSB 3
`define HPC_TRACK_LSB 0
`define HPC_GO_BIT 4
`define HPC_STANDBY_BIT 3
`define HPC_MODE_MSB 2
`define HPC_MODE_LSB 0
`define HPC_TIMEBASE_BIT 2
`define HPC_CUSTOM_BIT 1
`define HPC_CHAIN_BIT 0
`define HPC_ACCEL_BIT 0

// reset values
`define HPC_RST_BRAKE 3'h4
`define HPC_RST_TRACK 4'h3
`define HPC_RST_MODE 3'h0
`define HPC_RST_LEVEL 8'h00
`define HPC_RST_COEF1 8'h61
`define HPC_RST_ACCEL 1'h1

// override level: unity code and the code folded onto minus one
`define HPC_LEVEL_UNITY 18'sh0007F
`define HPC_LEVEL_MOST_NEG 8'h80

// frame durations in units of 10 us: 1.36, 5.44, 21.76, 43.52 and 87.04 ms
`define HPC_FRAME_1P36 14'h0088
`define HPC_FRAME_5P44 14'h0220
`define HPC_FRAME_21P76 14'h0880
`define HPC_FRAME_43P52 14'h1100
`define HPC_FRAME_87P04 14'h2200

`endif

// ---- hpc_pkg.sv ----
// types of the playback control bank
package hpc_pkg;

	typedef enum logic [2:0] {
		HPC_MODE_INACTIVE = 3'h0,
		HPC_MODE_DIRECT = 3'h1,
		HPC_MODE_PWM = 3'h2,
		HPC_MODE_REG_MEM = 3'h3,
		HPC_MODE_EDGE_MEM = 3'h4
	} hpc_mode_e;

	typedef enum logic [1:0] {
		HPC_ST_IDLE = 2'b00,
		HPC_ST_STANDBY = 2'b01,
		HPC_ST_PLAY = 2'b10
	} hpc_state_e;

endpackage

// ---- hpc_scale.sv ----
// direct drive level scaler for the two actuator ceilings
`timescale 1ns/1ps
`include "hpc_defines.svh"

module hpc_scale (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic enable,
	input wire logic [7:0] level,
	input wire logic accel_enable,
	input wire logic [7:0] actuator_absolute_ceiling,
	input wire logic [7:0] actuator_nominal_ceiling,
	output logic signed [8:0] scaled_absolute,
	output logic signed [8:0] scaled_nominal
);

	// 0x80 folds onto 0x81 so both give minus one
	wire logic [7:0] level_fold;
	wire logic signed [8:0] level_eff;
	wire logic signed [17:0] prod_abs;
	wire logic signed [17:0] prod_nom;
	wire logic signed [17:0] quot_abs;
	wire logic signed [17:0] quot_nom;

	assign level_fold = (level == `HPC_LEVEL_MOST_NEG) ? 8'h81 : level;
	// with acceleration on, negative codes give zero drive
	assign level_eff = (accel_enable && level[7]) ? 9'sh000 : $signed({level_fold[7], level_fold});
	assign prod_abs = level_eff * $signed({1'b0, actuator_absolute_ceiling});
	assign prod_nom = level_eff * $signed({1'b0, actuator_nominal_ceiling});
	// divide by 0x7F so that the top code gives exactly the ceiling
	assign quot_abs = prod_abs / `HPC_LEVEL_UNITY;
	assign quot_nom = prod_nom / `HPC_LEVEL_UNITY;

	// absolute ceiling only takes part while acceleration is on
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			scaled_absolute <= 9'sh000;
			scaled_nominal <= 9'sh000;
		end else begin
			scaled_absolute <= (enable && accel_enable) ? quot_abs[8:0] : 9'sh000;
			scaled_nominal <= enable ? quot_nom[8:0] : 9'sh000;
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	a_neg_accel_zero: assert property (@(posedge mclk) disable iff (!rst_n)
		(accel_enable && level[7]) |=> (scaled_absolute == 9'sh000 && scaled_nominal == 9'sh000))
		else $error("negative level with acceleration did not give zero");

	a_unity_level: assert property (@(posedge mclk) disable iff (!rst_n)
		(enable && level == 8'h7F) |=> scaled_nominal == $signed({1'b0, $past(actuator_nominal_ceiling)}))
		else $error("unity level did not pass the nominal ceiling");

	a_off_no_drive: assert property (@(posedge mclk) disable iff (!rst_n)
		(!enable || !accel_enable) |=> scaled_absolute == 9'sh000)
		else $error("absolute ceiling scaled outside its condition");

endmodule

// ---- hpc_regs.sv ----
// playback control register bank: mode, start and stop, chaining and drive scaling
//
// Function
// - three-bit mode: inactive, direct level, pwm, register-triggered, edge-triggered memory play
// - writing playback_go zero stops memory playback and returns to idle
// - writing playback_go one starts the selected memory sequence; taken only if the mode held before the write is a memory mode
// - after playback, standby if standby bit set, else idle; bit resets zero
// - direct mode scales absolute and/or nominal ceilings by the level
// - level is two's complement, 0x7F unity; negatives zero with acceleration
// - timebase bit picks the set of four frame durations
// - wave select zero gives step and ramp, one gives custom sine
// - chain bit in memory modes starts next sequence with no gap
// - chain bit self-clears when the chained sequence starts
// - first coefficient is a fraction of max current, resets 0x61
// - three-bit brake cutoff limit, resets 0x4
// - four-bit tracking pause limit, resets 0x3
// - acceleration enable resets one and steers the level scaling
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
`include "hpc_defines.svh"

module hpc_regs (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic edge_trigger,
	input wire logic seq_end,
	input wire logic [1:0] frame_len_sel,
	input wire logic [7:0] actuator_absolute_ceiling,
	input wire logic [7:0] actuator_nominal_ceiling,
	output logic [2:0] op_mode,
	output logic play_active,
	output logic standby_active,
	output logic seq_begin,
	output logic chain_next_sequence,
	output logic frame_timebase_select,
	output logic custom_wave_select,
	output logic [7:0] wave_shape_coefficient_one,
	output logic [2:0] brake_cutoff_limit,
	output logic [3:0] tracking_pause_limit,
	output logic accel_enable,
	output logic [13:0] frame_duration_10us,
	output logic signed [8:0] scaled_absolute,
	output logic signed [8:0] scaled_nominal
);

	////////////////////////////////////////////////////////////////////////////////
	// reset release

	logic rst_meta;
	logic rst_n;

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// register storage

	logic playback_go;
	logic standby_en;
	logic [7:0] direct_drive_level;
	hpc_pkg::hpc_state_e state;
	hpc_pkg::hpc_state_e next_state;
	logic next_seq_begin;

	wire logic wr_limits = reg_wr && (reg_addr == `HPC_OFS_LIMITS);
	wire logic wr_top = reg_wr && (reg_addr == `HPC_OFS_TOP);
	wire logic wr_level = reg_wr && (reg_addr == `HPC_OFS_LEVEL);
	wire logic wr_seq = reg_wr && (reg_addr == `HPC_OFS_SEQ);
	wire logic wr_coef1 = reg_wr && (reg_addr == `HPC_OFS_COEF1);
	wire logic wr_loopcfg = reg_wr && (reg_addr == `HPC_OFS_LOOPCFG);

	wire logic go_wr_one = wr_top && reg_wdata[`HPC_GO_BIT];
	wire logic go_wr_zero = wr_top && !reg_wdata[`HPC_GO_BIT];

	// memory modes are the only ones that play sequences or chain them
	wire logic mode_reg_mem = (op_mode == hpc_pkg::HPC_MODE_REG_MEM);
	wire logic mode_edge_mem = (op_mode == hpc_pkg::HPC_MODE_EDGE_MEM);
	wire logic mode_direct = (op_mode == hpc_pkg::HPC_MODE_DIRECT);
	wire logic mem_mode = mode_reg_mem || mode_edge_mem;

	wire logic start_req = mem_mode && (go_wr_one || (mode_edge_mem && edge_trigger));
	wire logic chain_go = (state == hpc_pkg::HPC_ST_PLAY) && seq_end && chain_next_sequence
		&& mem_mode && !go_wr_zero;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			brake_cutoff_limit <= `HPC_RST_BRAKE;
			tracking_pause_limit <= `HPC_RST_TRACK;
		end else if (wr_limits) begin
			brake_cutoff_limit <= reg_wdata[`HPC_BRAKE_MSB:`HPC_BRAKE_LSB];
			tracking_pause_limit <= reg_wdata[`HPC_TRACK_MSB:`HPC_TRACK_LSB];
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			playback_go <= 1'b0;
			standby_en <= 1'b0;
			op_mode <= `HPC_RST_MODE;
		end else if (wr_top) begin
			playback_go <= reg_wdata[`HPC_GO_BIT];
			standby_en <= reg_wdata[`HPC_STANDBY_BIT];
			op_mode <= reg_wdata[`HPC_MODE_MSB:`HPC_MODE_LSB];
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			direct_drive_level <= `HPC_RST_LEVEL;
			wave_shape_coefficient_one <= `HPC_RST_COEF1;
			accel_enable <= `HPC_RST_ACCEL;
		end else begin
			if (wr_level) begin
				direct_drive_level <= reg_wdata;
			end
			if (wr_coef1) begin
				wave_shape_coefficient_one <= reg_wdata;
			end
			if (wr_loopcfg) begin
				accel_enable <= reg_wdata[`HPC_ACCEL_BIT];
			end
		end
	end

	// a host write of the chain bit wins over the self-clear so a fresh request is kept
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			frame_timebase_select <= 1'b0;
			custom_wave_select <= 1'b0;
			chain_next_sequence <= 1'b0;
		end else if (wr_seq) begin
			frame_timebase_select <= reg_wdata[`HPC_TIMEBASE_BIT];
			custom_wave_select <= reg_wdata[`HPC_CUSTOM_BIT];
			chain_next_sequence <= reg_wdata[`HPC_CHAIN_BIT];
		end else if (chain_go) begin
			chain_next_sequence <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// playback state

	always_comb begin
		next_state = state;
		next_seq_begin = 1'b0;
		unique case (state)
			hpc_pkg::HPC_ST_PLAY: begin
				if (go_wr_zero || !mem_mode) begin
					next_state = hpc_pkg::HPC_ST_IDLE;
				end else if (chain_go) begin
					next_seq_begin = 1'b1;
				end else if (seq_end) begin
					next_state = standby_en ? hpc_pkg::HPC_ST_STANDBY : hpc_pkg::HPC_ST_IDLE;
				end
			end
			hpc_pkg::HPC_ST_IDLE, hpc_pkg::HPC_ST_STANDBY: begin
				if (start_req) begin
					next_state = hpc_pkg::HPC_ST_PLAY;
					next_seq_begin = 1'b1;
				end else if (go_wr_zero) begin
					next_state = hpc_pkg::HPC_ST_IDLE;
				end
			end
			default: begin
				next_state = hpc_pkg::HPC_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state <= hpc_pkg::HPC_ST_IDLE;
			seq_begin <= 1'b0;
		end else begin
			state <= next_state;
			seq_begin <= next_seq_begin;
		end
	end

	assign play_active = (state == hpc_pkg::HPC_ST_PLAY);
	assign standby_active = (state == hpc_pkg::HPC_ST_STANDBY);

	////////////////////////////////////////////////////////////////////////////////
	// frame timebase: the fast set is the slow set moved down by one step

	wire logic [13:0] frame_slow;
	wire logic [13:0] frame_fast;

	assign frame_slow = (frame_len_sel == 2'h0) ? `HPC_FRAME_5P44 :
		(frame_len_sel == 2'h1) ? `HPC_FRAME_21P76 :
		(frame_len_sel == 2'h2) ? `HPC_FRAME_43P52 : `HPC_FRAME_87P04;
	assign frame_fast = (frame_len_sel == 2'h0) ? `HPC_FRAME_1P36 :
		(frame_len_sel == 2'h1) ? `HPC_FRAME_5P44 :
		(frame_len_sel == 2'h2) ? `HPC_FRAME_21P76 : `HPC_FRAME_43P52;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			frame_duration_10us <= `HPC_FRAME_5P44;
		end else begin
			frame_duration_10us <= frame_timebase_select ? frame_fast : frame_slow;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// direct level scaling, only live in direct mode

	hpc_scale u_scale (
		.mclk(mclk),
		.rst_n(rst_n),
		.enable(mode_direct),
		.level(direct_drive_level),
		.accel_enable(accel_enable),
		.actuator_absolute_ceiling(actuator_absolute_ceiling),
		.actuator_nominal_ceiling(actuator_nominal_ceiling),
		.scaled_absolute(scaled_absolute),
		.scaled_nominal(scaled_nominal)
	);

	////////////////////////////////////////////////////////////////////////////////
	// read port: data one cycle after the strobe, unmapped reads give zero

	wire logic [7:0] rd_mux;

	assign rd_mux = (reg_addr == `HPC_OFS_LIMITS) ? {1'b0, brake_cutoff_limit, tracking_pause_limit} :
		(reg_addr == `HPC_OFS_TOP) ? {3'h0, playback_go, standby_en, op_mode} :
		(reg_addr == `HPC_OFS_LEVEL) ? direct_drive_level :
		(reg_addr == `HPC_OFS_SEQ) ? {5'h00, frame_timebase_select, custom_wave_select,
			chain_next_sequence} :
		(reg_addr == `HPC_OFS_COEF1) ? wave_shape_coefficient_one :
		(reg_addr == `HPC_OFS_LOOPCFG) ? {7'h00, accel_enable} :
		(reg_addr == `HPC_OFS_STATUS) ? {6'h00, standby_active, play_active} : 8'h00;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= rd_mux;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks

	logic mode_written;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			mode_written <= 1'b0;
		end else if (wr_top) begin
			mode_written <= 1'b1;
		end
	end

	sequence s_play_ends;
		play_active && seq_end && !go_wr_zero && !chain_go && mem_mode;
	endsequence

	sequence s_chain_restart;
		play_active && seq_end && chain_next_sequence && mem_mode && !go_wr_zero;
	endsequence

	a_mode_inactive: assert property (@(posedge mclk) disable iff (!rst_n)
		!mode_written |-> (op_mode == 3'h0 && !play_active))
		else $error("mode left inactive without a host write");

	a_stop_idle: assert property (@(posedge mclk) disable iff (!rst_n)
		(play_active && go_wr_zero) |=> (state == hpc_pkg::HPC_ST_IDLE && !seq_begin))
		else $error("stop write did not return to idle");

	a_start_play: assert property (@(posedge mclk) disable iff (!rst_n)
		(!play_active && mem_mode && go_wr_one) |=> (play_active && seq_begin) ##1 !seq_begin)
		else $error("start write did not begin one sequence");

	a_end_standby: assert property (@(posedge mclk) disable iff (!rst_n)
		(s_play_ends and standby_en) |=> standby_active)
		else $error("completed playback did not enter standby");

	a_end_idle: assert property (@(posedge mclk) disable iff (!rst_n)
		(s_play_ends and !standby_en) |=> (!standby_active && !play_active))
		else $error("completed playback did not enter idle");

	a_chain_gapless: assert property (@(posedge mclk) disable iff (!rst_n)
		s_chain_restart |=> (play_active && seq_begin))
		else $error("chained sequence did not start at once");

	a_chain_clear: assert property (@(posedge mclk) disable iff (!rst_n)
		(s_chain_restart ##0 !wr_seq) |=> !chain_next_sequence)
		else $error("chain bit not cleared at chained start");

	a_frame_fast: assert property (@(posedge mclk) disable iff (!rst_n)
		(frame_timebase_select && frame_len_sel == 2'h0) |=> frame_duration_10us == 14'h0088)
		else $error("fast timebase shortest frame wrong");

	a_read_coef: assert property (@(posedge mclk) disable iff (!rst_n)
		(reg_rd && reg_addr == `HPC_OFS_COEF1) |=> reg_rdata == $past(wave_shape_coefficient_one))
		else $error("coefficient read back wrong");

	a_direct_only: assert property (@(posedge mclk) disable iff (!rst_n)
		(!mode_direct ##1 !mode_direct) |-> scaled_nominal == 9'sh000)
		else $error("drive scaled outside direct mode");

endmodule

// ---- hpc_host.sv ----
// host model driving the register port of the playback control bank
`timescale 1ns/1ps

module hpc_host (
	input wire logic mclk,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [7:0] reg_rdata
);
	logic back_emf_sensing_enable;

	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		back_emf_sensing_enable = 1'b1;
	end

	////////////////////////////////////////////////////////////////////////////////
	// released lines show the inverse so a stale value never passes for a fresh one
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		#1 d = reg_rdata;
	endtask

	// sensing follows the wave kind: on for step and ramp, off for custom sine
	task automatic set_wave(input logic [2:0] bits);
		back_emf_sensing_enable <= ~bits[1];
		wr(8'h24, {5'h00, bits});
	endtask
endmodule

// ---- hpc_regs_test.sv ----
// self-checking bench for the playback control register bank
`timescale 1ns/1ps

module hpc_regs_test;
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic edge_trigger = 1'b0;
	logic seq_end = 1'b0;
	logic [1:0] frame_len_sel = 2'h0;
	logic [7:0] abs_ceil = 8'hC8;
	logic [7:0] nom_ceil = 8'h64;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, rdv;
	logic reg_wr, reg_rd;
	logic [2:0] op_mode, brake_cutoff_limit;
	logic play_active, standby_active, seq_begin, chain_next_sequence;
	logic frame_timebase_select, custom_wave_select, accel_enable;
	logic [7:0] wave_shape_coefficient_one;
	logic [3:0] tracking_pause_limit;
	logic [13:0] frame_duration_10us;
	logic signed [8:0] scaled_absolute, scaled_nominal;
	int fails = 0;
	int compares = 0;
	logic [7:0] ra [7] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h30};
	logic [7:0] rv [7] = '{8'h43, 8'h00, 8'h00, 8'h00, 8'h00, 8'h61, 8'h01};
	logic [13:0] fr [8] = '{14'h0220, 14'h0880, 14'h1100, 14'h2200,
		14'h0088, 14'h0220, 14'h0880, 14'h1100};
	logic [7:0] lv [7] = '{8'h7F, 8'h40, 8'h01, 8'h00, 8'hFF, 8'h81, 8'h80};

	always #5 mclk = ~mclk;

	hpc_host host (.mclk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);

	hpc_regs uut (.mclk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.edge_trigger, .seq_end, .frame_len_sel, .actuator_absolute_ceiling(abs_ceil),
		.actuator_nominal_ceiling(nom_ceil), .op_mode, .play_active, .standby_active,
		.seq_begin, .chain_next_sequence, .frame_timebase_select, .custom_wave_select,
		.wave_shape_coefficient_one, .brake_cutoff_limit, .tracking_pause_limit,
		.accel_enable, .frame_duration_10us, .scaled_absolute, .scaled_nominal);

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic end_sim;
		if (fails == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// one-cycle pulse from the sequencer side: 1 ends a sequence, 0 is an edge trigger
	task automatic pulse(input bit is_end);
		@(posedge mclk);
		if (is_end) seq_end <= 1'b1;
		else edge_trigger <= 1'b1;
		@(posedge mclk);
		seq_end <= 1'b0;
		edge_trigger <= 1'b0;
		#1;
	endtask

	// 0x80 folds onto 0x81; acceleration hides negatives and gates the absolute ceiling
	function automatic logic [15:0] exp_scale(input logic [7:0] lvl, input logic [7:0] ceil,
		input logic acc, input logic is_abs);
		int v;
		v = int'($signed(lvl));
		if (v == -128) v = -127;
		if ((acc && v < 0) || (is_abs && !acc)) v = 0;
		v = v * int'(ceil) / 127;
		return 16'(v);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(posedge mclk);
		rst_b <= 1'b1;
		repeat (2) @(posedge mclk);
		#1 chk("op_mode", op_mode, 16'h0000);
		chk("frame", frame_duration_10us, 16'h0220);
		chk("accel", accel_enable, 16'h0001);
		for (int i = 0; i < 7; i++) begin
			host.rd(ra[i], rdv);
			chk("reset read", rdv, rv[i]);
		end
		host.wr(8'h20, 8'hFF);
		host.rd(8'h20, rdv);
		chk("limits", rdv, 16'h007F);
		chk("brake", brake_cutoff_limit, 16'h0007);
		chk("track", tracking_pause_limit, 16'h000F);
		host.wr(8'h25, 8'hFF);
		host.rd(8'h25, rdv);
		chk("coef", rdv, 16'h00FF);
		chk("coef out", wave_shape_coefficient_one, 16'h00FF);
		host.set_wave(3'h2);
		chk("sensing", host.back_emf_sensing_enable, 16'h0000);
		host.rd(8'h24, rdv);
		chk("seq ctl", rdv, 16'h0002);
		chk("custom", custom_wave_select, 16'h0001);
		host.set_wave(3'h0);
		#1 chk("normal", custom_wave_select, 16'h0000);
		chk("sensing", host.back_emf_sensing_enable, 16'h0001);
		for (int t = 0; t < 2; t++) begin
			host.wr(8'h24, {5'h00, t[0], 2'h0});
			#1 chk("timebase", frame_timebase_select, 16'(t));
			for (int s = 0; s < 4; s++) begin
				@(posedge mclk);
				frame_len_sel <= s[1:0];
				repeat (2) @(posedge mclk);
				#1 chk("frame", frame_duration_10us, 16'(fr[t * 4 + s]));
			end
		end
		// go is only taken when the mode held before the write is a memory mode
		for (int m = 0; m < 5; m++) begin
			host.wr(8'h22, 8'(m));
			host.wr(8'h22, 8'(m) | 8'h10);
			#1 chk("mode", op_mode, 16'(m));
			chk("go", play_active, 16'(m > 2));
			chk("begin", seq_begin, 16'(m > 2));
			host.wr(8'h22, 8'(m));
			#1 chk("stop", play_active, 16'h0000);
		end
		host.wr(8'h22, 8'h13);
		pulse(1);
		chk("idle", {play_active, standby_active}, 16'h0000);
		host.wr(8'h22, 8'h0B);
		host.wr(8'h22, 8'h1B);
		pulse(1);
		chk("standby", {play_active, standby_active}, 16'h0001);
		host.rd(8'h31, rdv);
		chk("status", rdv, 16'h0002);
		host.wr(8'h22, 8'h03);
		#1 chk("leave standby", standby_active, 16'h0000);
		host.wr(8'h24, 8'h01);
		host.wr(8'h22, 8'h13);
		pulse(1);
		chk("chain begin", seq_begin, 16'h0001);
		chk("chain play", play_active, 16'h0001);
		chk("chain clear", chain_next_sequence, 16'h0000);
		pulse(1);
		chk("chain end", play_active, 16'h0000);
		host.wr(8'h22, 8'h03);
		pulse(0);
		chk("edge in reg mode", play_active, 16'h0000);
		host.wr(8'h22, 8'h04);
		pulse(0);
		chk("edge start", play_active, 16'h0001);
		host.wr(8'h22, 8'h04);
		#1 chk("edge stop", play_active, 16'h0000);
		host.wr(8'h22, 8'h01);
		for (int a = 1; a >= 0; a--) begin
			host.wr(8'h30, 8'(a));
			#1 chk("accel", accel_enable, 16'(a));
			for (int i = 0; i < 7; i++) begin
				host.wr(8'h23, lv[i]);
				@(posedge mclk);
				#1 chk("nominal", scaled_nominal, exp_scale(lv[i], nom_ceil, a[0], 1'b0));
				chk("absolute", scaled_absolute, exp_scale(lv[i], abs_ceil, a[0], 1'b1));
			end
		end
		host.wr(8'h22, 8'h00);
		@(posedge mclk);
		#1 chk("off mode", scaled_nominal, 16'h0000);
		end_sim;
	end

	// the whole sequence needs well under a thousand cycles
	initial begin
		#50000;
		fails++;
		end_sim;
	end
endmodule
